// *** spmi_pkg.sv ***
// Purpose: constants shared by the stereo microphone input block
// Assumes: 32-bit classic Wishbone, word index times four is the byte address
// Notes: register indices are word indices
`default_nettype none

package spmi_pkg;

	// ------------------------------------------------------------
	// register word indices
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_POWER_MANAGEMENT_ONE = 6'h19;
	localparam logic [5:0] IDX_PIN_FUNCTION = 6'h1a;
	localparam logic [5:0] IDX_CLOCK_CONFIG = 6'h1b;
	localparam logic [5:0] IDX_CONVERTER_VOLUME = 6'h1c;
	localparam logic [5:0] IDX_MIC_STATUS = 6'h1d;

	// ------------------------------------------------------------
	// field positions and codes
	// ------------------------------------------------------------
	localparam int POS_MIC_PATH_SELECT = 10;
	localparam int POS_LEFT_CONVERTER_ENABLE = 3;
	localparam int POS_RIGHT_CONVERTER_ENABLE = 2;
	localparam int POS_HIGH_PERFORMANCE = 8;
	localparam int POS_SYSTEM_CLOCK_ENABLE = 9;
	localparam logic [4:0] FN_MIC_DATA_IN = 5'h14;
	localparam logic [4:0] FN_MIC_CLOCK_OUT = 5'h13;

	// ------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------
	localparam logic [15:0] RST_POWER_MANAGEMENT_ONE = 16'h0000;
	localparam logic [19:0] RST_PIN_FUNCTION = 20'h00000;
	localparam logic [9:0] RST_CLOCK_CONFIG = 10'h000;
	localparam logic [15:0] RST_CONVERTER_VOLUME = 16'hc0c0;

	// ------------------------------------------------------------
	// mic clock frequencies and half-period counts
	// ------------------------------------------------------------
	localparam longint SYS_HZ = 250000000;
	localparam longint MIC_HZ_0 = 1024000;
	localparam longint MIC_HZ_1 = 1411200;
	localparam longint MIC_HZ_2 = 1536000;
	localparam longint MIC_HZ_3 = 2048000;
	localparam longint MIC_HZ_4 = 2822400;
	localparam longint MIC_HZ_5 = 3072000;
	localparam logic [7:0] HALF_0 = 8'(SYS_HZ / (2 * MIC_HZ_0));
	localparam logic [7:0] HALF_1 = 8'(SYS_HZ / (2 * MIC_HZ_1));
	localparam logic [7:0] HALF_2 = 8'(SYS_HZ / (2 * MIC_HZ_2));
	localparam logic [7:0] HALF_3 = 8'(SYS_HZ / (2 * MIC_HZ_3));
	localparam logic [7:0] HALF_4 = 8'(SYS_HZ / (2 * MIC_HZ_4));
	localparam logic [7:0] HALF_5 = 8'(SYS_HZ / (2 * MIC_HZ_5));

	// mic clock generator states
	typedef enum logic [1:0] {MIC_IDLE, MIC_HIGH, MIC_LOW} spmi_state_e;

endpackage

`default_nettype wire

// *** spmi_stereo_pdm_mic_input.sv ***
// Purpose: stereo one-bit microphone input with clock output and path select
// Assumes: clock is the system clock; pins sampled through two flip-flops
// Notes: registers on classic Wishbone, one word per register
//
// Functional notes
// R01: data input accepted on pin five or six when set to data-input code.
// R02: mic clock driven on another pin programmed with the clock-output code.
// R03: clock may go on pins two, three, five, six; data only five or six.
// R04: while mic input is enabled the clock runs on its configured pin.
// R05: left mic drives data in clock high, right mic in clock low.
// R06: capture left at end of high phase, right at end of low phase.
// R07: each mic releases the shared line while the other drives it.
// R08: mic select replaces converter path into the core; clear uses converters.
// R09: left and right converter enables gate the matching mic channels.
// R10: software enables filters and sets sample rate before relying on processing.
// R11: converter volume settings apply to the mic channels, no separate control.
// R12: mic clock from system clock, frequency chosen from rate, ratio, performance bit.
// R13: clock runs while mic path enabled on a pin and system clock enabled.
// R14: high performance bit resets to zero, the reduced power option.
// R15: software programs only listed valid rate and ratio pairs.
// R16: system clock present and enabled whenever the interface is used.
// R17: software never uses ratios 64, 128 or 192 with the mic input.
// R18: software mutes volume before clearing a converter enable.
// R19: one bit per channel per clock period delivered, channels kept apart.
//
// Added by the designer: the Wishbone interface to the registers.
`default_nettype none

module spmi_stereo_pdm_mic_input
	import spmi_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// wishbone slave
	input wire logic [7:0] wbAdr,
	input wire logic [31:0] wbWriteData,
	output logic [31:0] wbReadData,
	input wire logic wbWe,
	input wire logic [3:0] wbSel,
	input wire logic wbStb,
	input wire logic wbCyc,
	output logic wbAck,
	// general pins two and three, output side only
	output logic pinTwoOut,
	output logic pinTwoOe,
	output logic pinThreeOut,
	output logic pinThreeOe,
	// general pins five and six
	input wire logic pinFiveIn,
	output logic pinFiveOut,
	output logic pinFiveOe,
	input wire logic pinSixIn,
	output logic pinSixOut,
	output logic pinSixOe,
	// converter path from the analogue side
	input wire logic adcLeftBit,
	input wire logic adcRightBit,
	input wire logic adcStrobe,
	// stream into the digital core
	output logic coreLeftBit,
	output logic coreRightBit,
	output logic coreLeftValid,
	output logic coreRightValid,
	output logic [7:0] coreLeftVolume,
	output logic [7:0] coreRightVolume
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------

	// merge write data into a word by byte lane
	function automatic logic [31:0] laneMerge(input logic [31:0] old,
		input logic [31:0] wr, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[8*i +: 8] = wr[8*i +: 8];
			end
		end
		return res;
	endfunction

	// frequency class from rate, ratio and performance bit
	function automatic logic [2:0] freqClass(input logic [3:0] rate,
		input logic [3:0] ratio, input logic hp);
		logic hi;
		logic [2:0] cls;
		hi = hp && (ratio != 4'h0);
		cls = 3'h0;
		if (rate == 4'h0) begin
			cls = hi ? 3'h3 : 3'h0;
		end else if (rate == 4'h1) begin
			cls = hi ? 3'h4 : 3'h1;
		end else if (rate == 4'h2) begin
			cls = hi ? 3'h5 : 3'h2;
		end else if (rate == 4'h3) begin
			cls = hp ? 3'h3 : 3'h0;
		end else if (rate == 4'h4) begin
			cls = hp ? 3'h4 : 3'h1;
		end else if (rate == 4'h5) begin
			cls = hp ? 3'h5 : 3'h2;
		end else if (rate == 4'h6) begin
			cls = 3'h3;
		end else if (rate == 4'h7 || rate == 4'h9) begin
			cls = (hp || !ratio[0]) ? 3'h4 : 3'h1;
		end else begin
			cls = (hp || !ratio[0]) ? 3'h5 : 3'h2;
		end
		return cls;
	endfunction

	// supported ratio columns per rate, low power and high performance
	function automatic logic configValid(input logic [3:0] rate,
		input logic [3:0] ratio, input logic hp);
		logic [7:0] mask;
		mask = 8'h00;
		if (rate == 4'h0) begin
			mask = hp ? 8'hf5 : 8'hfd;
		end else if (rate == 4'h1 || rate == 4'h2) begin
			mask = hp ? 8'h15 : 8'h7d;
		end else if (rate == 4'h3) begin
			mask = hp ? 8'h79 : 8'h7f;
		end else if (rate == 4'h4 || rate == 4'h5 || rate == 4'h6) begin
			mask = hp ? 8'h15 : 8'h3f;
		end else if (rate == 4'h7 || rate == 4'h8) begin
			mask = hp ? 8'h15 : 8'h1f;
		end else if (rate == 4'h9 || rate == 4'ha) begin
			mask = 8'h05;
		end
		return !ratio[3] && mask[ratio[2:0]];
	endfunction

	// half period in system clocks for a class
	function automatic logic [7:0] halfCount(input logic [2:0] cls);
		logic [7:0] h;
		h = HALF_5;
		if (cls == 3'h0) begin
			h = HALF_0;
		end else if (cls == 3'h1) begin
			h = HALF_1;
		end else if (cls == 3'h2) begin
			h = HALF_2;
		end else if (cls == 3'h3) begin
			h = HALF_3;
		end else if (cls == 3'h4) begin
			h = HALF_4;
		end
		return h;
	endfunction

	// ------------------------------------------------------------
	// reset release and pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] resetSync_reg;
	logic rstN;
	logic [1:0] fiveSync_reg;
	logic [1:0] sixSync_reg;

	// reset leaves through two flip-flops
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			resetSync_reg <= 2'b00;
		end else begin
			resetSync_reg <= {resetSync_reg[0], 1'b1};
		end
	end
	assign rstN = resetSync_reg[1];

	// data pins pass two flip-flops before use
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			fiveSync_reg <= 2'b00;
			sixSync_reg <= 2'b00;
		end else begin
			fiveSync_reg <= {fiveSync_reg[0], pinFiveIn};
			sixSync_reg <= {sixSync_reg[0], pinSixIn};
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [15:0] powerManagementOne_reg;
	logic [19:0] pinFunction_reg;
	logic [9:0] clockConfig_reg;
	logic [15:0] converterVolume_reg;
	logic ack_reg;
	logic [31:0] readData_reg;
	logic [31:0] readData_next;
	logic [31:0] statusWord;
	logic busReq;
	logic [5:0] regIdx;
	logic wrPower;
	logic wrPin;
	logic wrClock;
	logic wrVolume;

	// bus decode
	assign busReq = wbCyc && wbStb && !ack_reg;
	assign regIdx = wbAdr[7:2];
	assign wrPower = busReq && wbWe && regIdx == IDX_POWER_MANAGEMENT_ONE;
	assign wrPin = busReq && wbWe && regIdx == IDX_PIN_FUNCTION;
	assign wrClock = busReq && wbWe && regIdx == IDX_CLOCK_CONFIG;
	assign wrVolume = busReq && wbWe && regIdx == IDX_CONVERTER_VOLUME;
	assign readData_next =
		(regIdx == IDX_POWER_MANAGEMENT_ONE) ? {16'h0000, powerManagementOne_reg} :
		(regIdx == IDX_PIN_FUNCTION) ? {12'h000, pinFunction_reg} :
		(regIdx == IDX_CLOCK_CONFIG) ? {22'h000000, clockConfig_reg} :
		(regIdx == IDX_CONVERTER_VOLUME) ? {16'h0000, converterVolume_reg} :
		(regIdx == IDX_MIC_STATUS) ? statusWord : 32'h00000000;

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			ack_reg <= 1'b0;
			readData_reg <= 32'h00000000;
		end else begin
			ack_reg <= busReq;
			readData_reg <= busReq ? readData_next : 32'h00000000;
		end
	end

	// software writes, per byte lane
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			powerManagementOne_reg <= RST_POWER_MANAGEMENT_ONE;
			pinFunction_reg <= RST_PIN_FUNCTION;
			clockConfig_reg <= RST_CLOCK_CONFIG; // R14
			converterVolume_reg <= RST_CONVERTER_VOLUME;
		end else begin
			if (wrPower) begin
				powerManagementOne_reg <= 16'(laneMerge(32'(powerManagementOne_reg),
					wbWriteData, wbSel));
			end
			if (wrPin) begin
				pinFunction_reg <= 20'(laneMerge(32'(pinFunction_reg), wbWriteData, wbSel));
			end
			if (wrClock) begin
				clockConfig_reg <= 10'(laneMerge(32'(clockConfig_reg), wbWriteData, wbSel));
			end
			if (wrVolume) begin
				converterVolume_reg <= 16'(laneMerge(32'(converterVolume_reg),
					wbWriteData, wbSel));
			end
		end
	end

	assign wbAck = ack_reg;
	assign wbReadData = readData_reg;

	// ------------------------------------------------------------
	// pin roles and clock setup
	// ------------------------------------------------------------
	logic [4:0] fnTwo;
	logic [4:0] fnThree;
	logic [4:0] fnFive;
	logic [4:0] fnSix;
	logic clkOnTwo;
	logic clkOnThree;
	logic clkOnFive;
	logic clkOnSix;
	logic dataOnFive;
	logic dataOnSix;
	logic dataLine;
	logic micSelect;
	logic leftEnable;
	logic rightEnable;
	logic cfgValid;
	logic runClock;
	logic [2:0] micClass;
	logic [7:0] halfLoad;

	// function fields per pin
	assign fnTwo = pinFunction_reg[4:0];
	assign fnThree = pinFunction_reg[9:5];
	assign fnFive = pinFunction_reg[14:10];
	assign fnSix = pinFunction_reg[19:15];
	assign clkOnTwo = fnTwo == FN_MIC_CLOCK_OUT; // R03
	assign clkOnThree = fnThree == FN_MIC_CLOCK_OUT; // R03
	assign clkOnFive = fnFive == FN_MIC_CLOCK_OUT; // R02
	assign clkOnSix = fnSix == FN_MIC_CLOCK_OUT; // R02
	assign dataOnFive = fnFive == FN_MIC_DATA_IN; // R01
	assign dataOnSix = fnSix == FN_MIC_DATA_IN; // R01
	assign dataLine = dataOnFive ? fiveSync_reg[1] : sixSync_reg[1]; // R03

	// control bits and clock choice
	assign micSelect = powerManagementOne_reg[POS_MIC_PATH_SELECT];
	assign leftEnable = powerManagementOne_reg[POS_LEFT_CONVERTER_ENABLE];
	assign rightEnable = powerManagementOne_reg[POS_RIGHT_CONVERTER_ENABLE];
	assign micClass = freqClass(clockConfig_reg[3:0], clockConfig_reg[7:4],
		clockConfig_reg[POS_HIGH_PERFORMANCE]); // R12
	assign cfgValid = configValid(clockConfig_reg[3:0], clockConfig_reg[7:4],
		clockConfig_reg[POS_HIGH_PERFORMANCE]);
	assign halfLoad = halfCount(micClass) - 8'h01; // R12
	assign runClock = micSelect && clockConfig_reg[POS_SYSTEM_CLOCK_ENABLE] && cfgValid
		&& (clkOnTwo || clkOnThree || clkOnFive || clkOnSix)
		&& (dataOnFive || dataOnSix); // R13

	// ------------------------------------------------------------
	// mic clock generator and capture
	// ------------------------------------------------------------
	spmi_state_e state_reg;
	spmi_state_e state_next;
	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic micClock_reg;
	logic micClock_next;
	logic leftBit_reg;
	logic rightBit_reg;
	logic takeLeft;
	logic takeRight;

	// phase sequencing; each phase ends when the count hits zero, a high phase also as soon as runClock drops
	always_comb begin
		state_next = state_reg;
		count_next = count_reg - 8'h01;
		micClock_next = micClock_reg;
		takeLeft = 1'b0;
		takeRight = 1'b0;
		case (state_reg)
			MIC_IDLE: begin
				count_next = halfLoad;
				if (runClock) begin
					state_next = MIC_HIGH; // R04
					micClock_next = 1'b1;
				end
			end
			MIC_HIGH: begin
				if (!runClock) begin
					state_next = MIC_IDLE;
					micClock_next = 1'b0;
				end else if (count_reg == 8'h00) begin
					takeLeft = 1'b1; // R06
					state_next = MIC_LOW;
					count_next = halfLoad;
					micClock_next = 1'b0;
				end
			end
			MIC_LOW: begin
				if (count_reg == 8'h00) begin
					takeRight = 1'b1; // R06
					count_next = halfLoad;
					state_next = runClock ? MIC_HIGH : MIC_IDLE;
					micClock_next = runClock;
				end
			end
			default: begin
				state_next = MIC_IDLE;
			end
		endcase
	end

	// generator state
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			state_reg <= MIC_IDLE;
			count_reg <= 8'h00;
			micClock_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			micClock_reg <= micClock_next;
		end
	end

	// captured bits, left at end of high, right at end of low
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			leftBit_reg <= 1'b0;
			rightBit_reg <= 1'b0;
		end else begin
			if (takeLeft) begin
				leftBit_reg <= dataLine; // R06
			end
			if (takeRight) begin
				rightBit_reg <= dataLine; // R06
			end
		end
	end

	// ------------------------------------------------------------
	// pin drivers
	// ------------------------------------------------------------
	logic [3:0] pinOut_reg;
	logic [3:0] pinOe_reg;

	// clock pins driven only while configured; data pins never driven
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			pinOut_reg <= 4'h0;
			pinOe_reg <= 4'h0;
		end else begin
			pinOe_reg <= {clkOnSix, clkOnFive, clkOnThree, clkOnTwo}; // R02
			pinOut_reg <= {4{micClock_reg}} & {clkOnSix, clkOnFive, clkOnThree, clkOnTwo};
		end
	end

	assign pinTwoOut = pinOut_reg[0];
	assign pinTwoOe = pinOe_reg[0];
	assign pinThreeOut = pinOut_reg[1];
	assign pinThreeOe = pinOe_reg[1];
	assign pinFiveOut = pinOut_reg[2];
	assign pinFiveOe = pinOe_reg[2];
	assign pinSixOut = pinOut_reg[3];
	assign pinSixOe = pinOe_reg[3];

	// ------------------------------------------------------------
	// core input selection
	// ------------------------------------------------------------
	logic srcValid;
	logic srcLeft;
	logic srcRight;
	logic coreLeft_reg;
	logic coreRight_reg;
	logic coreLeftValid_reg;
	logic coreRightValid_reg;
	logic [15:0] volume_reg;

	// mic pair replaces converter path when selected
	assign srcValid = micSelect ? takeRight : adcStrobe; // R08
	assign srcLeft = micSelect ? leftBit_reg : adcLeftBit; // R08
	assign srcRight = micSelect ? dataLine : adcRightBit; // R19

	// one pulse per period, each channel gated by its enable
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			coreLeft_reg <= 1'b0;
			coreRight_reg <= 1'b0;
			coreLeftValid_reg <= 1'b0;
			coreRightValid_reg <= 1'b0;
			volume_reg <= RST_CONVERTER_VOLUME;
		end else begin
			coreLeftValid_reg <= srcValid && leftEnable; // R09
			coreRightValid_reg <= srcValid && rightEnable; // R09
			if (srcValid) begin
				coreLeft_reg <= srcLeft && leftEnable; // R19
				coreRight_reg <= srcRight && rightEnable; // R19
			end
			volume_reg <= converterVolume_reg; // R11
		end
	end

	assign coreLeftBit = coreLeft_reg;
	assign coreRightBit = coreRight_reg;
	assign coreLeftValid = coreLeftValid_reg;
	assign coreRightValid = coreRightValid_reg;
	assign coreLeftVolume = volume_reg[7:0];
	assign coreRightVolume = volume_reg[15:8];

	// status word for software
	assign statusWord = {25'h0000000, rightBit_reg, leftBit_reg, micClass,
		cfgValid, state_reg != MIC_IDLE};

endmodule

`default_nettype wire

// *** spmi_mic_asserts.sv ***
// Purpose: port-level checker for the stereo microphone input block
// Assumes: single clock domain, reset_n active low
// Notes: bound to the top module, sees its ports only
`default_nettype none

module spmi_mic_asserts
	import spmi_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// bus side
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbAck,
	input wire logic [31:0] wbReadData,
	// general pins
	input wire logic pinTwoOut,
	input wire logic pinTwoOe,
	input wire logic pinThreeOut,
	input wire logic pinThreeOe,
	input wire logic pinFiveOut,
	input wire logic pinFiveOe,
	input wire logic pinSixOut,
	input wire logic pinSixOe,
	// core side
	input wire logic coreLeftValid,
	input wire logic coreRightValid,
	input wire logic [7:0] coreLeftVolume,
	input wire logic [7:0] coreRightVolume
);
	// ------------------------------------------------------------
	// helper logic
	// ------------------------------------------------------------
	logic [7:0] highCnt_reg;
	wire logic [3:0] outVec = {pinSixOut, pinFiveOut, pinThreeOut, pinTwoOut};
	wire logic [3:0] oeVec = {pinSixOe, pinFiveOe, pinThreeOe, pinTwoOe};
	wire logic micClk = |(outVec & oeVec);
	wire logic validAny = coreLeftValid | coreRightValid;

	// length of the current high phase, saturating
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			highCnt_reg <= 8'h00;
		end else begin
			highCnt_reg <= micClk ? highCnt_reg + 8'(highCnt_reg != 8'hff) : 8'h00;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_ack_answer;
		wbCyc && wbStb && !wbAck |=> wbAck;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("no ack after request");
	property p_ack_pulse;
		wbAck |=> !wbAck;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_rd_quiet;
		!wbAck |-> wbReadData == 32'h0;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside ack");
	property p_out_needs_oe;
		(outVec & ~oeVec) == 4'h0;
	endproperty
	a_out_needs_oe: assert property (p_out_needs_oe) else $error("pin high without enable");
	property p_pins_agree;
		((outVec ^ {4{micClk}}) & oeVec) == 4'h0;
	endproperty
	a_pins_agree: assert property (p_pins_agree) else $error("clock pins disagree");
	property p_low_min;
		$fell(micClk) |=> !micClk [*8];
	endproperty
	a_low_min: assert property (p_low_min) else $error("low phase too short");
	property p_high_max;
		micClk |-> highCnt_reg <= 8'd121;
	endproperty
	a_high_max: assert property (p_high_max) else $error("high phase too long");
	property p_valid_pulse;
		validAny |=> !validAny [*8];
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("core valid too dense");
	property p_volume_reset;
		$rose(reset_n) |-> coreLeftVolume == 8'hc0 && coreRightVolume == 8'hc0;
	endproperty
	a_volume_reset: assert property (p_volume_reset) else $error("volume not at reset value");
endmodule

bind spmi_stereo_pdm_mic_input spmi_mic_asserts chk (.clock, .reset_n, .wbCyc, .wbStb, .wbAck,
	.wbReadData, .pinTwoOut, .pinTwoOe, .pinThreeOut, .pinThreeOe, .pinFiveOut, .pinFiveOe,
	.pinSixOut, .pinSixOe, .coreLeftValid, .coreRightValid, .coreLeftVolume, .coreRightVolume);

`default_nettype wire

// *** spmi_mic_pair_model.sv ***
// Purpose: two one-bit microphones sharing one data line
// Assumes: mic clock seen through the system clock
// Notes: undriven line toggles every cycle
`default_nettype none

module spmi_mic_pair_model (
	// system clock
	input wire logic clock,
	// link side
	input wire logic micClk,
	input wire logic active,
	output logic micData,
	// bits offered by the bench
	input wire logic nextLeft,
	input wire logic nextRight,
	// pair notice for the bench
	output logic pairStrobe,
	output logic pairLeft,
	output logic pairRight
);
	timeunit 1ns;
	timeprecision 1ps;
	logic clkSeen = 1'b0;
	logic idleLevel = 1'b0;

	// new pair of bits at each rising mic clock
	always @(posedge clock) begin
		clkSeen <= micClk;
		pairStrobe <= micClk && !clkSeen && active;
		if (micClk && !clkSeen) begin
			pairLeft <= nextLeft;
			pairRight <= nextRight;
		end
		idleLevel <= ~micData;
	end

	// left talks while high, right while low, each silent in the other phase
	assign micData = !active ? idleLevel : (micClk ? pairLeft : pairRight);
endmodule

`default_nettype wire

// *** tb.sv ***
// Purpose: self-checking bench for the stereo microphone input block
// Assumes: 250 MHz system clock, classic Wishbone master
// Notes: stream results checked against a queue
`default_nettype none

module tb
	import spmi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] wbAdr = 8'h00;
	logic [31:0] wbWriteData = 32'h0;
	logic [3:0] wbSel = 4'hf;
	logic wbWe = 1'b0, wbStb = 1'b0, wbCyc = 1'b0, adcLeftBit = 1'b0, adcRightBit = 1'b0;
	logic adcStrobe = 1'b0, nextLeft = 1'b0, nextRight = 1'b0, enL = 1'b0, enR = 1'b0;
	logic micNoise = 1'b0;
	logic [31:0] rd;
	logic [3:0] expQ[$];
	int failCount = 0, checks = 0, seed = 12273;
	wire logic [31:0] wbReadData;
	wire logic wbAck, pinTwoOut, pinTwoOe, pinThreeOut, pinThreeOe, pinFiveOut, pinFiveOe;
	wire logic pinSixOut, pinSixOe, coreLeftBit, coreRightBit, coreLeftValid, coreRightValid;
	wire logic [7:0] coreLeftVolume, coreRightVolume;
	wire logic micData, pairStrobe, pairLeft, pairRight;
	wire logic [3:0] outVec = {pinSixOut, pinFiveOut, pinThreeOut, pinTwoOut};
	wire logic [3:0] oeVec = {pinSixOe, pinFiveOe, pinThreeOe, pinTwoOe};
	wire logic micClk = |(outVec & oeVec);
	wire logic micActive = |oeVec;
	wire logic [3:0] coreNow = {coreLeftValid, coreRightValid, coreLeftBit, coreRightBit};
	wire logic pinFiveIn = pinFiveOe ? pinFiveOut : micData;
	wire logic pinSixIn = pinSixOe ? pinSixOut : micData;
	// H, sys en, left en, right en, hp, ratio, rate, clock pin, data pin
	localparam logic [27:0] ROWS [8] = '{28'h28e0802, 28'h58c1713, 28'h3db2032, 28'h7ae2023,
		28'h00f2210, 28'h00e5802, 28'h00e8802, 28'h0060802};
	localparam logic [31:0] RSTV [4] = '{32'(RST_POWER_MANAGEMENT_ONE), 32'(RST_PIN_FUNCTION),
		32'(RST_CLOCK_CONFIG), 32'(RST_CONVERTER_VOLUME)};
	localparam logic [31:0] MASKS [4] = '{32'hffff, 32'hfffff, 32'h3ff, 32'hffff};

	spmi_stereo_pdm_mic_input uut (.clock, .reset_n, .wbAdr, .wbWriteData, .wbReadData, .wbWe,
		.wbSel, .wbStb, .wbCyc, .wbAck, .pinTwoOut, .pinTwoOe, .pinThreeOut, .pinThreeOe,
		.pinFiveIn, .pinFiveOut, .pinFiveOe, .pinSixIn, .pinSixOut, .pinSixOe, .adcLeftBit,
		.adcRightBit, .adcStrobe, .coreLeftBit, .coreRightBit, .coreLeftValid, .coreRightValid,
		.coreLeftVolume, .coreRightVolume);
	spmi_mic_pair_model mics (.clock, .micClk, .active(micActive), .micData, .nextLeft,
		.nextRight, .pairStrobe, .pairLeft, .pairRight);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failCount++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wb(input logic we, input logic [5:0] idx, input logic [31:0] d);
		int n;
		@(posedge clock);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= {idx, 2'b00};
		wbWriteData <= d;
		@(posedge clock);
		for (n = 1; wbAck !== 1'b1 && n < 20; n++) @(posedge clock);
		rd = wbReadData;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		if (n >= 20) failCount++;
	endtask

	task automatic summarize();
		$display("tb: %0d checks, %0d mismatches", checks, failCount);
		if (failCount == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// clock, random bits, expectations, monitor, watchdog
	// ------------------------------------------------------------
	initial forever #2 clock = ~clock;

	// mic bits offered, converter noise while mics selected
	always @(posedge clock) begin
		nextLeft <= 1'($random(seed));
		nextRight <= 1'($random(seed));
		if (micNoise) begin
			adcStrobe <= 1'($random(seed));
			adcLeftBit <= 1'($random(seed));
		end
	end

	// note the pair each mic period carries
	always @(posedge clock) begin
		if (pairStrobe === 1'b1 && (enL || enR)) begin
			expQ.push_back({enL, enR, pairLeft & enL, pairRight & enR});
		end
	end

	// compare each core result with the oldest note
	always @(posedge clock) begin
		if (coreNow[3:2] !== 2'b00) begin
			check(32'(coreNow), 32'(expQ.size() ? expQ.pop_front() : 4'h0));
		end
	end

	initial begin
		repeat (60000) @(posedge clock);
		$display("tb: watchdog expired");
		failCount++;
		summarize();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int n, h;
		logic [27:0] r;
		logic [19:0] fn;
		logic [31:0] d;
		logic l, rr;
		repeat (6) @(posedge clock);
		reset_n <= 1'b1;
		repeat (4) @(posedge clock);
		// reset values, read-back, restore
		for (int k = 0; k < 4; k++) begin
			wb(1'b0, IDX_POWER_MANAGEMENT_ONE + 6'(k), 32'h0);
			check(rd, RSTV[k]);
			d = $random(seed);
			wb(1'b1, IDX_POWER_MANAGEMENT_ONE + 6'(k), d);
			wb(1'b0, IDX_POWER_MANAGEMENT_ONE + 6'(k), 32'h0);
			check(rd, d & MASKS[k]);
			wb(1'b1, IDX_POWER_MANAGEMENT_ONE + 6'(k), RSTV[k]);
		end
		wb(1'b1, 6'h00, 32'hffffffff);
		wb(1'b0, 6'h00, 32'h0);
		check(rd, 32'h0);
		wb(1'b0, IDX_MIC_STATUS, 32'h0);
		d = rd;
		wb(1'b1, IDX_MIC_STATUS, ~d);
		wb(1'b0, IDX_MIC_STATUS, 32'h0);
		check(rd, d);
		d = $random(seed);
		wb(1'b1, IDX_CONVERTER_VOLUME, d);
		repeat (2) @(posedge clock);
		check(32'({coreRightVolume, coreLeftVolume}), d & 32'hffff);
		$display("tb: register test done");
		// converter path under each enable pair
		for (int e = 0; e < 4; e++) begin
			enL = e[1];
			enR = e[0];
			wb(1'b1, IDX_POWER_MANAGEMENT_ONE, 32'(e) << 2);
			for (int k = 0; k < 4; k++) begin
				l = 1'($random(seed));
				rr = 1'($random(seed));
				@(posedge clock);
				adcLeftBit <= l;
				adcRightBit <= rr;
				adcStrobe <= 1'b1;
				if (e != 0) expQ.push_back({enL, enR, l & enL, rr & enR});
				@(posedge clock);
				adcStrobe <= 1'b0;
				repeat (9) @(posedge clock);
			end
		end
		$display("tb: converter path test done");
		// mic configurations: rate set before the path is enabled
		for (int i = 0; i < 8; i++) begin
			r = ROWS[i];
			fn = '0;
			fn[5 * r[7:4] +: 5] = FN_MIC_CLOCK_OUT;
			fn[5 * r[3:0] +: 5] = FN_MIC_DATA_IN;
			wb(1'b1, IDX_PIN_FUNCTION, 32'(fn));
			wb(1'b1, IDX_CLOCK_CONFIG, {22'h0, r[19], r[16], r[15:12], r[11:8]});
			enL = r[18];
			enR = r[17];
			wb(1'b1, IDX_POWER_MANAGEMENT_ONE, {21'h0, 1'b1, 6'h0, r[18], r[17], 2'b00});
			micNoise <= 1'b1;
			for (n = 0; micClk !== 1'b1 && n < 600; n++) @(posedge clock);
			for (h = 0; micClk === 1'b1 && h < 300; h++) @(posedge clock);
			check(32'(h), 32'(r[27:20]));
			check(32'(oeVec), 32'(4'h1 << r[7:4]));
			repeat (8 * r[27:20]) @(posedge clock);
			micNoise <= 1'b0;
			@(posedge clock);
			adcStrobe <= 1'b0;
			wb(1'b1, IDX_CONVERTER_VOLUME, 32'h0);
			wb(1'b1, IDX_POWER_MANAGEMENT_ONE, 32'h0);
			repeat (300) @(posedge clock);
			expQ.delete();
			$display("tb: mic configuration %0d done", i);
		end
		summarize();
	end
endmodule

`default_nettype wire
